// file: design/ssp_rate_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.vh"

module ssp_rate_gen (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       run_i,
  input  wire       hold_i,
  input  wire [1:0] rate_sel_i,
  input  wire       timer_tick_i,
  output reg        half_tick_o
);

  reg [4:0] cnt;

  // Half a bit period, in system clocks, minus one.
  function [4:0] reload;
    input [1:0] sel;
    reg   [6:0] per;
    reg   [5:0] half;
    begin
      per = `SSP_SYS_PER_BIT4;
      case (sel)
        2'h1:    per = `SSP_SYS_PER_BIT16;
        2'h2:    per = `SSP_SYS_PER_BIT64;
        default: per = `SSP_SYS_PER_BIT4;
      endcase
      half   = per[6:1] - 6'h01;
      reload = half[4:0];
    end
  endfunction

  // Holding freezes the count so a paused transfer resumes where it stood.
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt         <= 5'h00;
      half_tick_o <= 1'b0;
    end else if (hold_i) begin
      half_tick_o <= 1'b0;
    end else if ({2'b00, rate_sel_i} == `SSP_MODE_TIMER) begin
      half_tick_o <= timer_tick_i;
    end else if (cnt == reload(rate_sel_i)) begin
      cnt         <= 5'h00;
      half_tick_o <= 1'b1;
    end else begin
      cnt         <= cnt + 5'h01;
      half_tick_o <= 1'b0;
    end
  end

endmodule // ssp_rate_gen

`default_nettype wire

// file: design/ssp_spi_port.v
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.vh"

module ssp_spi_port (
  input  wire       mclk_i,
  input  wire       sys_rst_i,
  input  wire [2:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  input  wire       sleep_i,
  input  wire       timer_two_tick_i,
  input  wire       sck_i,
  output wire       sck_o,
  output wire       sck_oe_n_o,
  input  wire       data_in_pin_i,
  output wire       data_out_pin_o,
  output wire       data_out_pin_oe_n_o,
  input  wire       slave_sel_n_i,
  output wire       port_irq_flag_o,
  output reg        wake_o,
  output wire       port_active_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg       write_collision_flag;
  reg       receive_overflow_flag;
  reg       port_enable;
  reg       clock_idle_polarity;
  reg [3:0] port_mode_select;
  reg       input_sample_phase;
  reg       clock_edge_select;
  reg       buffer_full_flag;
  reg [7:0] rx_tx_buffer;
  reg       port_irq_flag;
  reg [1:0] port_pin_direction;
  reg [7:0] tx_shift;
  reg [7:0] serial_shift_register;
  reg       master_busy;
  reg [4:0] edge_cnt;
  reg [3:0] bit_cnt;
  reg       sck_drive;
  reg       sck_prev;

  wire       sck_s;
  wire       din_s;
  wire       ss_n_s;
  wire       half_tick;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Master edges are numbered from 0; the sample edge parity follows
  // the edge select and is pushed one half period on by sample phase.
  function smp_edge;
    input [4:0] h;
    input       ce;
    input       sp;
    begin
      smp_edge = (h[0] == (~ce ^ sp)) && !(h == 5'h00 && !ce);
    end
  endfunction

  // The first bit is already on the pin, so edge 0 never shifts.
  function shift_edge;
    input [4:0] h;
    input       ce;
    begin
      shift_edge = (h[0] == ce) && (h != 5'h00);
    end
  endfunction

  // ****************************************************************
  // Pin inputs
  // ****************************************************************
  ssp_sync2 #(
    .WIDTH (3)
  ) u_sync (
    .clk_i (mclk_i),
    .rst_i (sys_rst_i),
    .d_i   ({sck_i, data_in_pin_i, slave_sel_n_i}),
    .q_o   ({sck_s, din_s, ss_n_s})
  );

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire is_master  = port_enable && (port_mode_select[3:2] == 2'b00);
  wire is_slave   = port_enable &&
                    ((port_mode_select == `SSP_MODE_SLAVE_SS) ||
                     (port_mode_select == `SSP_MODE_SLAVE));
  wire ss_block   = is_slave && (port_mode_select == `SSP_MODE_SLAVE_SS) &&
                    ss_n_s;
  wire slave_live = is_slave && !ss_block;

  // ****************************************************************
  // Slave clock edges
  // ****************************************************************
  wire sck_change = (sck_s != sck_prev);
  wire lead_edge  = sck_change && (sck_prev == clock_idle_polarity);
  wire trail_edge = sck_change && (sck_prev != clock_idle_polarity);
  wire s_sample   = slave_live &&
                    (clock_edge_select ? lead_edge : trail_edge);
  wire s_shift    = slave_live && (bit_cnt != 4'h0) &&
                    (clock_edge_select ? trail_edge : lead_edge);
  wire s_done     = s_sample && (bit_cnt == `SSP_LAST_BIT);

  // ****************************************************************
  // Master clock and edges
  // ****************************************************************
  // Sleep freezes the master clock; the slave path ignores sleep.
  // With two pin flip-flops on data-in, the fastest rate only sees the
  // slave's next bit when the sample phase bit is set.
  ssp_rate_gen u_rate (
    .clk_i        (mclk_i),
    .rst_i        (sys_rst_i),
    .run_i        (master_busy && is_master),
    .hold_i       (sleep_i),
    .rate_sel_i   (port_mode_select[1:0]),
    .timer_tick_i (timer_two_tick_i),
    .half_tick_o  (half_tick)
  );

  wire       m_tick   = half_tick && master_busy && is_master;
  wire [4:0] m_last   = (!clock_edge_select && input_sample_phase) ?
                        `SSP_EDGES : `SSP_EDGE_LAST;
  wire       m_sample = m_tick &&
                        smp_edge(edge_cnt, clock_edge_select,
                                 input_sample_phase);
  wire       m_shift  = m_tick && shift_edge(edge_cnt, clock_edge_select);
  wire       m_done   = m_tick && (edge_cnt == m_last);

  // ****************************************************************
  // Shared datapath
  // ****************************************************************
  wire [7:0] rx_next  = {serial_shift_register[6:0], din_s};
  wire [7:0] m_byte   = m_sample ? rx_next : serial_shift_register;
  wire       busy_any = master_busy || (is_slave && bit_cnt != 4'h0);
  wire       buf_wr   = reg_wr_i && (reg_addr_i == `SSP_ADDR_BUFFER);
  wire       buf_rd   = reg_rd_i && (reg_addr_i == `SSP_ADDR_BUFFER);
  wire       buf_take = buf_wr && !busy_any;
  wire       ctl_wr   = reg_wr_i && (reg_addr_i == `SSP_ADDR_CONTROL);
  wire       sts_wr   = reg_wr_i && (reg_addr_i == `SSP_ADDR_STATUS);
  wire       irq_wr   = reg_wr_i && (reg_addr_i == `SSP_ADDR_IRQ);
  wire       dir_wr   = reg_wr_i && (reg_addr_i == `SSP_ADDR_PIN_DIR);
  wire       s_over   = s_done && buffer_full_flag && !buf_rd;

  // ****************************************************************
  // Registers, shifter and flags
  // ****************************************************************
  // Hardware set statements follow the software writes so a set that
  // lands in the same cycle as a clear is kept.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      write_collision_flag  <= 1'b0;
      receive_overflow_flag <= 1'b0;
      port_enable           <= 1'b0;
      clock_idle_polarity   <= 1'b0;
      port_mode_select      <= 4'h0;
      input_sample_phase    <= 1'b0;
      clock_edge_select     <= 1'b0;
      buffer_full_flag      <= 1'b0;
      rx_tx_buffer          <= 8'h00;
      port_irq_flag         <= 1'b0;
      port_pin_direction    <= `SSP_RST_PIN_DIR;
      tx_shift              <= 8'h00;
      serial_shift_register <= 8'h00;
      master_busy           <= 1'b0;
      edge_cnt              <= 5'h00;
      bit_cnt               <= 4'h0;
      sck_drive             <= 1'b0;
      sck_prev              <= 1'b0;
      wake_o                <= 1'b0;
    end else begin
      sck_prev <= sck_s;
      wake_o   <= 1'b0;
      if (ctl_wr) begin
        write_collision_flag  <= reg_wdata_i[`SSP_CTL_COLLISION];
        receive_overflow_flag <= reg_wdata_i[`SSP_CTL_OVERFLOW];
        port_enable           <= reg_wdata_i[`SSP_CTL_ENABLE];
        clock_idle_polarity   <= reg_wdata_i[`SSP_CTL_IDLE_POL];
        port_mode_select      <= reg_wdata_i[3:0];
      end
      if (sts_wr) begin
        input_sample_phase <= reg_wdata_i[`SSP_STS_SAMPLE];
        clock_edge_select  <= reg_wdata_i[`SSP_STS_EDGE];
      end
      if (irq_wr && reg_wdata_i[0]) begin
        port_irq_flag <= 1'b0;
      end
      if (dir_wr) begin
        port_pin_direction <= reg_wdata_i[1:0];
      end
      if (buf_rd) begin
        buffer_full_flag <= 1'b0;
      end
      if (buf_wr && busy_any) begin
        write_collision_flag <= 1'b1;
      end
      if (buf_take) begin
        rx_tx_buffer <= reg_wdata_i;
        tx_shift     <= reg_wdata_i;
        if (is_master) begin
          master_busy <= 1'b1;
          edge_cnt    <= 5'h00;
        end
      end
      if (m_tick) begin
        edge_cnt <= edge_cnt + 5'h01;
        if (edge_cnt < `SSP_EDGES) begin
          sck_drive <= ~sck_drive;
        end
        if (m_sample) begin
          serial_shift_register <= rx_next;
        end
        if (m_shift) begin
          tx_shift <= {tx_shift[6:0], 1'b0};
        end
        if (m_done) begin
          master_busy      <= 1'b0;
          edge_cnt         <= 5'h00;
          rx_tx_buffer     <= m_byte;
          buffer_full_flag <= 1'b1;
          port_irq_flag    <= 1'b1;
        end
      end
      if (!master_busy) begin
        sck_drive <= clock_idle_polarity;
      end
      if (s_sample) begin
        serial_shift_register <= rx_next;
        bit_cnt <= s_done ? 4'h0 : bit_cnt + 4'h1;
      end
      if (s_shift) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
      if (s_done) begin
        port_irq_flag <= 1'b1;
        wake_o        <= 1'b1;
        if (s_over) begin
          receive_overflow_flag <= 1'b1;
        end else begin
          rx_tx_buffer     <= rx_next;
          buffer_full_flag <= 1'b1;
        end
      end
      if (!port_enable || ss_block) begin
        bit_cnt     <= 4'h0;
        edge_cnt    <= 5'h00;
        master_busy <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SSP_ADDR_BUFFER: begin
          reg_rdata_o <= rx_tx_buffer;
        end
        `SSP_ADDR_CONTROL: begin
          reg_rdata_o <= {write_collision_flag, receive_overflow_flag,
                          port_enable, clock_idle_polarity,
                          port_mode_select};
        end
        `SSP_ADDR_STATUS: begin
          reg_rdata_o <= {input_sample_phase, clock_edge_select,
                          5'h00, buffer_full_flag};
        end
        `SSP_ADDR_IRQ: begin
          reg_rdata_o <= {7'h00, port_irq_flag};
        end
        `SSP_ADDR_PIN_DIR: begin
          reg_rdata_o <= {6'h00, port_pin_direction};
        end
        default: begin
          reg_rdata_o <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  // A pin is driven only while the port owns it and its direction bit
  // says output; otherwise it is released to general I/O.
  assign sck_o               = sck_drive;
  assign sck_oe_n_o          = !(is_master &&
                                 !port_pin_direction[`SSP_DIR_CLOCK]);
  assign data_out_pin_o      = tx_shift[7];
  assign data_out_pin_oe_n_o = !((is_master || slave_live) &&
                                 !port_pin_direction[`SSP_DIR_DATA_OUT]);
  assign port_irq_flag_o     = port_irq_flag;
  assign port_active_o       = port_enable;

endmodule // ssp_spi_port

`default_nettype wire

// file: design/ssp_sync2.v
`timescale 1ns/1ps
`default_nettype none

module ssp_sync2 #(
  parameter WIDTH = 3
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] d_i,
  output reg  [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {WIDTH{1'b0}};
      q_o  <= {WIDTH{1'b0}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // ssp_sync2

`default_nettype wire

// file: inc/ssp_map.vh
// Summary of operation
// - Eight bits shifted in move to the buffer, setting buffer-full and irq.
// - Reading the buffer clears buffer-full; it shows an unread byte.
// - Buffer write during a transfer is dropped and sets collision, bit 7.
// - Slave byte over an unread byte sets overflow, bit 6, and is lost.
// - Overflow is never set in master mode.
// - Enable, bit 5, gives the pins to the port; clear releases them.
// - Bit 4 sets clock idle level: 1 high, 0 low.
// - Modes 0000, 0001, 0010 are master clock/4, /16, /64; 0011 timer/2.
// - Mode 0100 is slave gated by select; 0101 slave, select ignored.
// - Bytes move most significant bit first.
// - In master mode a buffer write starts an 8-bit transfer at once.
// - Master keeps receiving with data-out released as an input.
// - Slave shifts a bit per clock pulse; irq on the final bit.
// - Slave shifting runs during sleep; a received byte wakes the device.
// - Drive on the programmed edge, capture on the other (master with sample phase 1 captures on the drive edge); same idle level.
// - With edge select set, data-out is valid before the first clock edge.
// - Next byte may arrive while the previous one waits unread.
// - A buffer write loads buffer and shift register together.
// - Master samples at end of output time when 1, middle when 0.
// - Edge select 1 transmits on active-to-idle edge, 0 on the other.
// - Port reset or disable forces the bit counter to zero.
`ifndef SSP_MAP_VH
`define SSP_MAP_VH

`define SSP_ADDR_BUFFER   3'h0
`define SSP_ADDR_CONTROL  3'h1
`define SSP_ADDR_STATUS   3'h2
`define SSP_ADDR_IRQ      3'h3
`define SSP_ADDR_PIN_DIR  3'h4

`define SSP_CTL_COLLISION 7
`define SSP_CTL_OVERFLOW  6
`define SSP_CTL_ENABLE    5
`define SSP_CTL_IDLE_POL  4
`define SSP_STS_SAMPLE    7
`define SSP_STS_EDGE      6
`define SSP_STS_FULL      0
`define SSP_DIR_DATA_OUT  0
`define SSP_DIR_CLOCK     1

`define SSP_MODE_DIV4     4'h0
`define SSP_MODE_DIV16    4'h1
`define SSP_MODE_DIV64    4'h2
`define SSP_MODE_TIMER    4'h3
`define SSP_MODE_SLAVE_SS 4'h4
`define SSP_MODE_SLAVE    4'h5

`define SSP_RST_CONTROL   8'h00
`define SSP_RST_STATUS    8'h00
`define SSP_RST_PIN_DIR   2'h3

`define SSP_SYS_PER_BIT4  7'h04
`define SSP_SYS_PER_BIT16 7'h10
`define SSP_SYS_PER_BIT64 7'h40
`define SSP_LAST_BIT      4'h7
`define SSP_EDGES         5'h10
`define SSP_EDGE_LAST     5'h0f

`endif

// file: sim/ssp_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far-end SPI peer, clock idle low
// ****************************************
module ssp_far_end (
  input  wire logic clk_i,
  input  wire logic sck_line_i,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i,
  output var  logic sck_o,
  output wire logic din_o,
  output var  logic sel_n_o
);
  logic [7:0] sh;
  logic [7:0] rx;
  logic [5:0] cnt;
  logic [5:0] half;
  logic [4:0] edges;
  logic       sck_q;
  logic       dlast;
  // A released data-out line shows the inverse of its last driven value.
  wire        dline = dout_oe_n_i ? ~dlast : dout_i;
  assign din_o = sh[7];
  initial begin
    sck_o = 1'b0;
    sel_n_o = 1'b1;
    sh = 8'h00;
    sck_q = 1'b0;
    dlast = 1'b0;
    cnt = 6'h00;
    half = 6'h00;
    edges = 5'h00;
    rx = 8'h00;
  end
  always @(posedge clk_i) begin
    sck_q <= sck_line_i;
    if (!dout_oe_n_i)
      dlast <= dout_i;
    cnt <= cnt + 6'h01;
    if (sck_line_i != sck_q) begin
      half <= cnt;
      cnt <= 6'h01;
      edges <= edges + 5'h01;
      if (sck_line_i)
        rx <= {rx[6:0], dline};
      else
        sh <= {sh[6:0], 1'b0};
    end
  end
  task automatic arm(input logic [7:0] b);
    sh <= b;
    edges <= 5'h00;
  endtask
  // Acts as master: eight clock pulses, six system cycles per half period.
  task automatic send(input logic [7:0] b);
    arm(b);
    sel_n_o <= 1'b0;
    repeat (16) begin
      repeat (6) @(posedge clk_i);
      sck_o <= ~sck_o;
    end
    repeat (6) @(posedge clk_i);
    sel_n_o <= 1'b1;
    @(posedge clk_i);
  endtask
endmodule // ssp_far_end
`default_nettype wire

// file: sim/ssp_spi_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the serial port
// ****************************************
module ssp_spi_port_assertions (
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       sck_o,
  input wire logic       sck_oe_n_o,
  input wire logic       data_out_pin_o,
  input wire logic       data_out_pin_oe_n_o,
  input wire logic       port_irq_flag_o,
  input wire logic       wake_o,
  input wire logic       port_active_o
);
  logic [5:0] ctl;
  logic       busy;
  wire        mst = ctl[5] && ctl[3:2] == 2'h0;
  wire        bwr = reg_wr_i && reg_addr_i == 3'h0;
  wire        cwr = reg_wr_i && reg_addr_i == 3'h1;
  // Shadow of the control bits and of a running master byte.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctl  <= 6'h00;
      busy <= 1'b0;
    end else begin
      if (cwr)
        ctl <= reg_wdata_i[5:0];
      if (bwr && mst && !busy)
        busy <= 1'b1;
      else if (port_irq_flag_o || !mst)
        busy <= 1'b0;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_port_enable: assert property (cwr |=> port_active_o == $past(reg_wdata_i[5]))
    else $error("port active does not follow enable");
  a_pins_release: assert property (!port_active_o |-> sck_oe_n_o && data_out_pin_oe_n_o)
    else $error("pins driven while port disabled");
  a_slave_clock: assert property (port_active_o && ctl[3:1] == 3'h2 |-> sck_oe_n_o)
    else $error("clock driven in slave mode");
  a_first_bit: assert property (bwr && mst && !busy |=> data_out_pin_o == $past(reg_wdata_i[7]))
    else $error("first data bit not presented");
  a_sck_start: assert property (bwr && mst && !busy |-> ##[2:70] $changed(sck_o))
    else $error("master clock did not start");
  a_idle_level: assert property (cwr && reg_wdata_i[5] && reg_wdata_i[3:2] == 2'h0 && !busy
    |=> ##1 sck_o == $past(reg_wdata_i[4], 2))
    else $error("clock not at idle level");
  a_wake_irq: assert property (wake_o |-> port_irq_flag_o)
    else $error("wake without flag");
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  c_wake: cover property (wake_o);
  c_master_done: cover property (mst && $rose(port_irq_flag_o));
  c_collide: cover property (bwr && busy);
endmodule // ssp_spi_port_assertions

bind ssp_spi_port ssp_spi_port_assertions u_chk (
  .mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .sck_o, .sck_oe_n_o,
  .data_out_pin_o, .data_out_pin_oe_n_o, .port_irq_flag_o, .wake_o, .port_active_o
);
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Serial port testbench
// ****************************************
module tb_top;
  logic       mclk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic       sleep_i = 1'b0;
  logic       timer_two_tick_i = 1'b0;
  wire  [7:0] reg_rdata_o;
  wire        sck_o, sck_oe_n_o, data_out_pin_o, data_out_pin_oe_n_o;
  wire        port_irq_flag_o, wake_o, port_active_o, far_sck, far_din, far_sel_n;
  wire        sck_line = sck_oe_n_o ? far_sck : sck_o;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         wakes = 0;
  logic [2:0] tdiv = 3'h0;
  logic [7:0] v;
  logic [2:0] ra [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
  logic [7:0] re [4] = '{8'h00, 8'h00, 8'h03, 8'h00};
  logic [7:0] hp [4] = '{8'h02, 8'h08, 8'h20, 8'h05};
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    tdiv <= (tdiv == 3'h4) ? 3'h0 : tdiv + 3'h1;
    timer_two_tick_i <= (tdiv == 3'h4);
    if (wake_o === 1'b1)
      wakes <= wakes + 1;
  end
  ssp_spi_port DUT (
    .mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .sleep_i, .timer_two_tick_i, .sck_i(sck_line), .sck_o, .sck_oe_n_o,
    .data_in_pin_i(far_din), .data_out_pin_o, .data_out_pin_oe_n_o,
    .slave_sel_n_i(far_sel_n), .port_irq_flag_o, .wake_o, .port_active_o
  );
  ssp_far_end far (
    .clk_i(mclk_i), .sck_line_i(sck_line), .dout_i(data_out_pin_o),
    .dout_oe_n_i(data_out_pin_oe_n_o), .sck_o(far_sck), .din_o(far_din), .sel_n_o(far_sel_n)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic print_verdict;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (port_irq_flag_o !== 1'b1 && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      print_verdict;
    end
    repeat (4) @(posedge mclk_i);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(ra[i]);
      chk(v, re[i]);
    end
    $display("reset values done");
    wr(3'h4, 8'h00);
    wr(3'h2, 8'hc0);
    for (int m = 0; m < 4; m++) begin
      wr(3'h1, 8'h00);
      wr(3'h1, {4'h2, m[3:0]});
      wr(3'h3, 8'h01);
      far.arm(8'hc3 ^ m[7:0]);
      wr(3'h0, 8'h96 ^ m[7:0]);
      wait_irq;
      chk(far.rx, 8'h96 ^ m[7:0]);
      chk({3'h0, far.edges}, 8'h10);
      chk({2'h0, far.half}, hp[m]);
      rd(3'h2);
      chk(v, 8'hc1);
      rd(3'h0);
      chk(v, 8'hc3 ^ m[7:0]);
      rd(3'h2);
      chk(v, 8'hc0);
      rd(3'h1);
      chk(v, {4'h2, m[3:0]});
      $display("master mode %0d done", m);
    end
    wr(3'h3, 8'h01);
    far.arm(8'h00);
    wr(3'h0, 8'ha1);
    wr(3'h0, 8'h5e);
    rd(3'h1);
    chk(v, 8'ha3);
    wait_irq;
    chk(far.rx, 8'ha1);
    wr(3'h1, 8'h23);
    rd(3'h1);
    chk(v, 8'h23);
    rd(3'h0);
    chk(v, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h1, 8'h31);
    repeat (3) @(posedge mclk_i);
    chk({7'h0, sck_o}, 8'h01);
    wr(3'h1, 8'h00);
    chk({6'h0, sck_oe_n_o, data_out_pin_oe_n_o}, 8'h03);
    $display("collision and polarity done");
    wr(3'h4, 8'h02);
    wr(3'h2, 8'h40);
    for (int m = 4; m < 6; m++) begin
      wr(3'h1, 8'h00);
      wr(3'h1, {4'h2, m[3:0]});
      wr(3'h3, 8'h01);
      wr(3'h0, 8'h3c + m[7:0]);
      sleep_i <= 1'b1;
      far.send(8'ha5 ^ m[7:0]);
      wait_irq;
      sleep_i <= 1'b0;
      chk(far.rx, 8'h3c + m[7:0]);
      rd(3'h0);
      chk(v, 8'ha5 ^ m[7:0]);
    end
    chk(wakes[7:0], 8'h02);
    far.send(8'h11);
    far.send(8'h22);
    rd(3'h1);
    chk(v, 8'h65);
    rd(3'h0);
    chk(v, 8'h11);
    $display("slave modes done");
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
